// *** core/pct_term.sv ***
// device-side termination for the program controlled adapter, with APB control
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - every device answers read ID (status, 0000) and device reset (control, 1111)
// - function lines pick read data, read status, write data or write control
// - strobe captures outbound data, or clears supplied data on read-with-reset
// - strobe in interrupt service clears request and interrupt info byte
// - device drives 16 data bits plus odd byte parity on reads and service
// - interrupt request held until serviced or any reset or halt
// - condition code placed with select and never changed while presented
// - select only after address and active tag, data valid; falls after tag
// - halt or machine check clears states, requests, read status, info bytes and write registers; read data and ID kept
// - system reset clears everything without exception
// - power-on reset holds full reset, its receiver never gated
// - each step waits on the partner; a timeout may end a stuck step
// - output order: setup, active, select, strobe, active falls, select falls
// - inbound data and code drop after the active tag falls
// - diagnostic lines are device dependent programmable controls
// - every interface line is active low
// - reserved functions 011 and 111 answered with command reject
// - interrupt request dropped on strobe leading edge
module pct_term #(
  parameter int unsigned NDEV      = pct_pkg::NDEV_DEF,
  parameter logic [3:0]  BASE_ADDR = 4'h0,
  parameter int unsigned TMO_CYC   = pct_pkg::TMO_CYCLES
) (
  input  wire logic        CLOCK_I,
  input  wire logic        SRST_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic        IO_ACTIVE_N_I,
  input  wire logic        ISVC_ACTIVE_N_I,
  input  wire logic        STROBE_N_I,
  input  wire logic [2:0]  FUNC_N_I,
  input  wire logic [3:0]  MOD_N_I,
  input  wire logic [3:0]  DEV_ADDR_N_I,
  input  wire logic [17:0] DBO_N_I,
  input  wire logic        MACHINE_CHECK_HALT_N_I,
  input  wire logic        SYS_RESET_N_I,
  input  wire logic        POWER_ON_RESET_N_I,
  input  wire logic        DIAG_MODE_N_I,
  input  wire logic        DIAG_MOD_N_I,
  output logic      [17:0] DBI_N_O,
  output logic      [15:0] IRQ_N_O,
  output logic      [2:0]  CC_N_O,
  output logic             SEL_RESP_N_O
);
  //////////////////////////////////////////////////////////////////////////////////////////////
  // tag synchronisers and pin decode
  pct_pkg::pct_tags_type tags_raw;
  pct_pkg::pct_tags_type tags_s;
  pct_pkg::pct_cmd_type  cmd_pin;
  pct_pkg::pct_cmd_type  cmd_r;
  pct_pkg::pct_state_type state_r;
  pct_pkg::pct_state_type state_nxt;

  assign tags_raw = {~IO_ACTIVE_N_I, ~ISVC_ACTIVE_N_I, ~STROBE_N_I, ~MACHINE_CHECK_HALT_N_I,
                     ~SYS_RESET_N_I, ~POWER_ON_RESET_N_I, ~DIAG_MODE_N_I, ~DIAG_MOD_N_I};

  pct_sync #(.W($bits(pct_pkg::pct_tags_type))) u_sync (
    .clk_i  (CLOCK_I),
    .srst_i (SRST_I),
    .d_i    (tags_raw),
    .q_o    (tags_s)
  );

  assign cmd_pin = {~FUNC_N_I, ~MOD_N_I, ~DEV_ADDR_N_I};

  logic [2:0]  ctrl_r;
  logic [3:0]  devsel_r;
  logic [5:0]  ccreg_r;
  logic        tmo_r;
  logic        perr_r;
  logic        halt_seen_r;
  logic [3:0]  idx_r;
  logic        isa_r;
  logic        sel_r;
  logic        strobed_r;
  logic        stb_d_r;
  logic [17:0] dbi_r;
  logic [2:0]  cc_r;
  logic [31:0] prdata_r;
  logic [$clog2(TMO_CYC+1)-1:0] tmo_cnt_r;

  logic [15:0] rdata_m [NDEV];
  logic [15:0] rstat_m [NDEV];
  logic [15:0] devid_m [NDEV];
  logic [15:0] iib_m   [NDEV];
  logic [15:0] wdata_m [NDEV];
  logic [15:0] wctl_m  [NDEV];
  logic        irq_m   [NDEV];
  logic [15:0] irq_vec;

  wire        clr_all  = SRST_I | tags_s.sysrst | tags_s.por;
  wire        halt_s   = tags_s.halt;
  wire        act_tag  = tags_s.ioa | tags_s.isa;
  wire        en       = ctrl_r[pct_pkg::CTRL_EN];
  wire        par_on   = ctrl_r[pct_pkg::CTRL_PAR];
  wire [3:0]  idx_pin  = cmd_pin.addr - BASE_ADDR;
  wire        hit      = ({1'b0, idx_pin} < 5'(NDEV));
  wire        start    = (state_r == pct_pkg::ST_IDLE) && en && act_tag && hit && !halt_s;
  wire        stb_rise = tags_s.stb & ~stb_d_r;
  wire        stb_act  = (state_r == pct_pkg::ST_RESP) && stb_rise && !strobed_r;
  wire        tmo_hit  = (state_r == pct_pkg::ST_RESP) && (32'(tmo_cnt_r) == TMO_CYC - 1);

  // command decode on the latched command
  wire is_rdata = !isa_r && (cmd_r.func[2:1] == pct_pkg::FN_RD);
  wire is_rstat = !isa_r && (cmd_r.func == pct_pkg::FN_RDSTAT);
  wire is_wdata = !isa_r && (cmd_r.func[2:1] == pct_pkg::FN_WD);
  wire is_wctl  = !isa_r && (cmd_r.func == pct_pkg::FN_WRCTL);
  wire is_rsv   = !isa_r && ((cmd_r.func == pct_pkg::FN_RES0) ||
                             (cmd_r.func == pct_pkg::FN_RES1));

  //////////////////////////////////////////////////////////////////////////////////////////////
  // parity: check outbound, generate inbound
  wire [15:0] dbo_data = ~DBO_N_I[15:0];
  wire [1:0]  dbo_par  = ~DBO_N_I[17:16];
  logic [1:0] dbo_exp;
  logic [1:0] dbi_par;
  logic [15:0] dbi_word;

  pct_parity #(.BYTES(2)) u_chk (
    .data_i (dbo_data),
    .par_o  (dbo_exp)
  );
  pct_parity #(.BYTES(2)) u_gen (
    .data_i (dbi_word),
    .par_o  (dbi_par)
  );

  wire par_bad = par_on && (dbo_par != dbo_exp);

  assign dbi_word = isa_r    ? iib_m[idx_r] :
                    is_rdata ? rdata_m[idx_r] :
                    is_rstat ? ((cmd_r.modif == pct_pkg::MOD_READID) ? devid_m[idx_r]
                                                                     : rstat_m[idx_r]) :
                    16'h0000;
  wire [17:0] dbi_val = {(par_on ? dbi_par : 2'b00), dbi_word};
  wire [2:0]  cc_val  = is_rsv ? ccreg_r[5:3] : ccreg_r[2:0];

  // strobe actions
  wire wd_cap  = stb_act && is_wdata && !par_bad;
  wire wc_cap  = stb_act && is_wctl && !par_bad;
  wire dev_rst = stb_act && is_wctl && (cmd_r.modif == pct_pkg::MOD_DEVRST);
  wire rd_clr  = stb_act && is_rdata && ctrl_r[pct_pkg::CTRL_RDRST];
  wire isv_clr = stb_act && isa_r;

  //////////////////////////////////////////////////////////////////////////////////////////////
  // handshake state machine
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      pct_pkg::ST_IDLE:  if (start) state_nxt = pct_pkg::ST_SETUP;
      pct_pkg::ST_SETUP: state_nxt = pct_pkg::ST_RESP;
      pct_pkg::ST_RESP: begin
        if (!act_tag) state_nxt = pct_pkg::ST_IDLE;
        else if (tmo_hit) state_nxt = pct_pkg::ST_HOLD;
      end
      pct_pkg::ST_HOLD:  if (!act_tag) state_nxt = pct_pkg::ST_IDLE;
      default:           state_nxt = pct_pkg::ST_IDLE;
    endcase
  end

  wire keep_resp = (state_nxt == pct_pkg::ST_RESP) && !halt_s;

  always_ff @(posedge CLOCK_I) begin
    if (clr_all || halt_s) begin
      state_r   <= pct_pkg::ST_IDLE;
      sel_r     <= 1'b0;
      strobed_r <= 1'b0;
      dbi_r     <= 18'h00000;
      cc_r      <= 3'h0;
      tmo_cnt_r <= '0;
    end else begin
      state_r   <= state_nxt;
      sel_r     <= (state_nxt == pct_pkg::ST_RESP);
      strobed_r <= (state_r == pct_pkg::ST_RESP) && (strobed_r || stb_act);
      dbi_r     <= (state_r == pct_pkg::ST_SETUP) ? dbi_val : (keep_resp ? dbi_r : 18'h00000);
      cc_r      <= (state_r == pct_pkg::ST_SETUP) ? cc_val : (keep_resp ? cc_r : 3'h0);
      tmo_cnt_r <= (state_r == pct_pkg::ST_RESP) ? tmo_cnt_r + 1'b1 : '0;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (clr_all) begin
      cmd_r   <= '0;
      idx_r   <= 4'h0;
      isa_r   <= 1'b0;
      stb_d_r <= 1'b0;
    end else begin
      stb_d_r <= tags_s.stb;
      if (start) begin
        cmd_r <= cmd_pin;
        idx_r <= idx_pin;
        isa_r <= tags_s.isa;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // APB slave
  wire apb_wr    = PSEL_I & PENABLE_I & PWRITE_I;
  wire h_ctrl    = (PADDR_I == pct_pkg::OFS_CTRL);
  wire h_sel     = (PADDR_I == pct_pkg::OFS_SEL);
  wire h_rdata   = (PADDR_I == pct_pkg::OFS_RDATA);
  wire h_rstat   = (PADDR_I == pct_pkg::OFS_RSTAT);
  wire h_devid   = (PADDR_I == pct_pkg::OFS_DEVID);
  wire h_wdata   = (PADDR_I == pct_pkg::OFS_WDATA);
  wire h_wctl    = (PADDR_I == pct_pkg::OFS_WCTL);
  wire h_irq     = (PADDR_I == pct_pkg::OFS_IRQ);
  wire h_iib     = (PADDR_I == pct_pkg::OFS_IIB);
  wire h_status  = (PADDR_I == pct_pkg::OFS_STATUS);
  wire h_cc      = (PADDR_I == pct_pkg::OFS_CC);
  wire mapped    = h_ctrl | h_sel | h_rdata | h_rstat | h_devid | h_wdata | h_wctl | h_irq |
                   h_iib | h_status | h_cc;
  wire sel_ok    = ({1'b0, devsel_r} < 5'(NDEV));
  wire [15:0] d_rdata = sel_ok ? rdata_m[devsel_r] : 16'h0000;
  wire [15:0] d_rstat = sel_ok ? rstat_m[devsel_r] : 16'h0000;
  wire [15:0] d_devid = sel_ok ? devid_m[devsel_r] : 16'h0000;
  wire [15:0] d_wdata = sel_ok ? wdata_m[devsel_r] : 16'h0000;
  wire [15:0] d_wctl  = sel_ok ? wctl_m[devsel_r] : 16'h0000;
  wire [15:0] d_iib   = sel_ok ? iib_m[devsel_r] : 16'h0000;
  wire [15:0] status  = {idx_r, 1'b0, cmd_r.func, 2'b00, halt_seen_r, tags_s.dmod,
                         tags_s.diag, perr_r, tmo_r, sel_r};
  wire [31:0] rd_mux  = h_ctrl   ? {29'h0, ctrl_r} :
                        h_sel    ? {28'h0, devsel_r} :
                        h_rdata  ? {16'h0, d_rdata} :
                        h_rstat  ? {16'h0, d_rstat} :
                        h_devid  ? {16'h0, d_devid} :
                        h_wdata  ? {16'h0, d_wdata} :
                        h_wctl   ? {16'h0, d_wctl} :
                        h_irq    ? {16'h0, irq_vec} :
                        h_iib    ? {16'h0, d_iib} :
                        h_status ? {16'h0, status} :
                        h_cc     ? {26'h0, ccreg_r} : 32'h0;
  wire w_sts = apb_wr & h_status;

  always_ff @(posedge CLOCK_I) begin
    if (clr_all) begin
      prdata_r    <= 32'h0;
      ctrl_r      <= pct_pkg::CTRL_RST;
      devsel_r    <= 4'h0;
      ccreg_r     <= pct_pkg::CC_RST;
      tmo_r       <= 1'b0;
      perr_r      <= 1'b0;
      halt_seen_r <= 1'b0;
    end else begin
      if (PSEL_I && !PENABLE_I) prdata_r <= rd_mux;
      if (apb_wr && h_ctrl) ctrl_r <= PWDATA_I[2:0];
      if (apb_wr && h_sel) devsel_r <= PWDATA_I[3:0];
      if (apb_wr && h_cc) ccreg_r <= PWDATA_I[5:0];
      tmo_r       <= tmo_hit | (tmo_r & ~(w_sts & PWDATA_I[pct_pkg::STS_TMO]));
      perr_r      <= (stb_act & par_bad & (is_wdata | is_wctl)) |
                     (perr_r & ~(w_sts & PWDATA_I[pct_pkg::STS_PERR]));
      halt_seen_r <= halt_s | (halt_seen_r & ~(w_sts & PWDATA_I[pct_pkg::STS_HALT]));
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // per-device storage and interrupt requests
  for (genvar g = 0; g < 16; g++) begin : g_dev
    if (g < NDEV) begin : g_on
      wire sw_g  = apb_wr && (devsel_r == 4'(g));
      wire lnk_g = (idx_r == 4'(g));
      wire set_g = apb_wr && h_irq && PWDATA_I[g];
      always_ff @(posedge CLOCK_I) begin
        if (clr_all) begin
          rdata_m[g] <= pct_pkg::WORD_RST;
          rstat_m[g] <= pct_pkg::WORD_RST;
          devid_m[g] <= pct_pkg::WORD_RST;
          iib_m[g]   <= pct_pkg::WORD_RST;
          wdata_m[g] <= pct_pkg::WORD_RST;
          wctl_m[g]  <= pct_pkg::WORD_RST;
          irq_m[g]   <= 1'b0;
        end else if (halt_s) begin
          rstat_m[g] <= pct_pkg::WORD_RST;
          iib_m[g]   <= pct_pkg::WORD_RST;
          wdata_m[g] <= pct_pkg::WORD_RST;
          wctl_m[g]  <= pct_pkg::WORD_RST;
          irq_m[g]   <= 1'b0;
        end else begin
          if (sw_g && h_rdata) rdata_m[g] <= PWDATA_I[15:0];
          else if (rd_clr && lnk_g) rdata_m[g] <= pct_pkg::WORD_RST;
          if (sw_g && h_rstat) rstat_m[g] <= PWDATA_I[15:0];
          if (sw_g && h_devid) devid_m[g] <= PWDATA_I[15:0];
          if (sw_g && h_iib) iib_m[g] <= PWDATA_I[15:0];
          else if ((isv_clr || dev_rst) && lnk_g) iib_m[g] <= pct_pkg::WORD_RST;
          if (wd_cap && lnk_g) wdata_m[g] <= dbo_data;
          if (wc_cap && lnk_g) wctl_m[g] <= dbo_data;
          irq_m[g] <= set_g | (irq_m[g] & ~((isv_clr || dev_rst) && lnk_g));
        end
      end
      assign irq_vec[g] = irq_m[g];
      assign IRQ_N_O[g] = ~irq_m[g];
    end else begin : g_off
      assign irq_vec[g] = 1'b0;
      assign IRQ_N_O[g] = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // outputs
  assign DBI_N_O      = ~dbi_r;
  assign CC_N_O       = ~cc_r;
  assign SEL_RESP_N_O = ~sel_r;
  assign PRDATA_O     = prdata_r;
  assign PREADY_O     = 1'b1;
  assign PSLVERR_O    = PSEL_I & PENABLE_I & ~mapped;

  //////////////////////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (clr_all);

  sequence s_setup;
    state_r == pct_pkg::ST_SETUP && !sel_r;
  endsequence
  sequence s_resp;
    state_r == pct_pkg::ST_RESP && sel_r;
  endsequence

  property p_order;
    start |=> s_setup ##1 s_resp;
  endproperty
  a_order: assert property (p_order) else $error("select not raised two cycles after tag");

  property p_sel_rise;
    $rose(sel_r) |-> $past(act_tag) && $past(state_r == pct_pkg::ST_SETUP);
  endproperty
  a_sel_rise: assert property (p_sel_rise) else $error("select raised without tag");

  property p_sel_hold;
    sel_r && act_tag && !tmo_hit && !halt_s |=> sel_r;
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("select dropped while tag active");

  property p_cc_stable;
    sel_r && $past(sel_r) |-> $stable(cc_r) && $stable(dbi_r);
  endproperty
  a_cc_stable: assert property (p_cc_stable) else $error("code changed while presented");

  property p_drop;
    state_r == pct_pkg::ST_RESP && !act_tag && !halt_s |=> !sel_r && dbi_r == 18'h0 && cc_r == 3'h0;
  endproperty
  a_drop: assert property (p_drop) else $error("inbound lines not dropped after tag fall");

  property p_isv_clear;
    isv_clr && !(apb_wr && h_irq && PWDATA_I[idx_r]) |=> !irq_vec[$past(idx_r)];
  endproperty
  a_isv_clear: assert property (p_isv_clear) else $error("request not cleared by strobe");

  property p_devrst;
    dev_rst && !(apb_wr && h_irq && PWDATA_I[idx_r]) |=> !irq_vec[$past(idx_r)] &&
      iib_m[$past(idx_r)] == 16'h0;
  endproperty
  a_devrst: assert property (p_devrst) else $error("device reset did not clear");

  property p_wcap;
    wd_cap |=> wdata_m[$past(idx_r)] == $past(dbo_data);
  endproperty
  a_wcap: assert property (p_wcap) else $error("write data not captured");

  property p_reject;
    state_r == pct_pkg::ST_SETUP && is_rsv && !halt_s |=> cc_r == ccreg_r[5:3] &&
      dbi_r[15:0] == 16'h0;
  endproperty
  a_reject: assert property (p_reject) else $error("reserved function not rejected");

  property p_parity;
    sel_r && par_on |-> (^{dbi_r[16], dbi_r[7:0]}) && (^{dbi_r[17], dbi_r[15:8]});
  endproperty
  a_parity: assert property (p_parity) else $error("inbound parity not odd");

  property p_halt;
    halt_s |=> state_r == pct_pkg::ST_IDLE && !sel_r && irq_vec == 16'h0;
  endproperty
  a_halt: assert property (p_halt) else $error("halt did not clear");

endmodule : pct_term
`default_nettype wire

// *** core/pct_pkg.sv ***
// shared constants and types for the parallel device termination block
package pct_pkg;

  localparam int unsigned NDEV_DEF   = 16;
  localparam int unsigned CLK_NS     = 100;
  localparam int unsigned TMO_NS     = 1000000;
  localparam int unsigned TMO_CYCLES = TMO_NS / CLK_NS;

  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_SEL    = 8'h04;
  localparam logic [7:0] OFS_RDATA  = 8'h08;
  localparam logic [7:0] OFS_RSTAT  = 8'h0C;
  localparam logic [7:0] OFS_DEVID  = 8'h10;
  localparam logic [7:0] OFS_WDATA  = 8'h14;
  localparam logic [7:0] OFS_WCTL   = 8'h18;
  localparam logic [7:0] OFS_IRQ    = 8'h1C;
  localparam logic [7:0] OFS_IIB    = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_CC     = 8'h28;

  // field positions
  localparam int unsigned CTRL_EN    = 0;
  localparam int unsigned CTRL_PAR   = 1;
  localparam int unsigned CTRL_RDRST = 2;
  localparam int unsigned STS_TMO    = 1;
  localparam int unsigned STS_PERR   = 2;
  localparam int unsigned STS_HALT   = 5;

  // reset values
  localparam logic [2:0]  CTRL_RST = 3'h0;
  localparam logic [5:0]  CC_RST   = 6'h0A;
  localparam logic [15:0] WORD_RST = 16'h0000;

  // function and modifier codes
  localparam logic [1:0] FN_RD     = 2'b00;
  localparam logic [1:0] FN_WD     = 2'b10;
  localparam logic [2:0] FN_RDSTAT = 3'b010;
  localparam logic [2:0] FN_WRCTL  = 3'b110;
  localparam logic [2:0] FN_RES0   = 3'b011;
  localparam logic [2:0] FN_RES1   = 3'b111;
  localparam logic [3:0] MOD_READID = 4'h0;
  localparam logic [3:0] MOD_DEVRST = 4'hF;

  typedef struct packed {
    logic [2:0] func;
    logic [3:0] modif;
    logic [3:0] addr;
  } pct_cmd_type;

  typedef struct packed {
    logic ioa;
    logic isa;
    logic stb;
    logic halt;
    logic sysrst;
    logic por;
    logic diag;
    logic dmod;
  } pct_tags_type;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_SETUP = 4'b0010,
    ST_RESP  = 4'b0100,
    ST_HOLD  = 4'b1000
  } pct_state_type;

endpackage : pct_pkg

// *** core/pct_sync.sv ***
// two-flop level synchroniser, one per bit
`timescale 1ns/100ps
`default_nettype none
module pct_sync #(
  parameter int unsigned W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  for (genvar b = 0; b < W; b++) begin : g_bit
    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        meta_r[b] <= 1'b0;
        sync_r[b] <= 1'b0;
      end else begin
        meta_r[b] <= d_i[b];
        sync_r[b] <= meta_r[b];
      end
    end
  end

  assign q_o = sync_r;
endmodule : pct_sync
`default_nettype wire

// *** core/pct_parity.sv ***
// odd parity per byte
`timescale 1ns/100ps
`default_nettype none
module pct_parity #(
  parameter int unsigned BYTES = 2
) (
  input  wire logic [8*BYTES-1:0] data_i,
  output logic      [BYTES-1:0]   par_o
);
  for (genvar b = 0; b < BYTES; b++) begin : g_byte
    assign par_o[b] = ~(^data_i[8*b +: 8]);
  end
endmodule : pct_parity
`default_nettype wire

// *** tb/pct_adapter.sv ***
// behavioural adapter model driving the device side link
`timescale 1ns/100ps
`default_nettype none
module pct_adapter (
  input  wire logic        clk_i,
  input  wire logic        sel_n_i,
  input  wire logic [17:0] dbi_n_i,
  input  wire logic [2:0]  cc_n_i,
  output logic             io_n_o,
  output logic             svc_n_o,
  output logic             stb_n_o,
  output logic      [2:0]  func_n_o,
  output logic      [3:0]  mod_n_o,
  output logic      [3:0]  addr_n_o,
  output logic      [17:0] dbo_n_o
);
  //////////////////////////////////////////////////////////////////////////////////////////////
  // all lines idle high, i.e. logical zero
  int hold_cyc = 0;
  initial begin
    {io_n_o, svc_n_o, stb_n_o, func_n_o, mod_n_o, addr_n_o} = '1;
    dbo_n_o = '1;
  end
  task automatic seq(input logic s, input logic [2:0] fn, input logic [3:0] md, ad,
                     input logic [15:0] d, input logic st,
                     output logic [17:0] bi, output logic [2:0] cc);
    logic wr;
    wr = !s && fn[2];
    @(posedge clk_i);
    func_n_o <= ~fn;
    mod_n_o  <= ~md;
    addr_n_o <= ~ad;
    dbo_n_o  <= wr ? ~{~^d[15:8], ~^d[7:0], d} : '1;
    repeat (2) @(posedge clk_i);
    if (s) svc_n_o <= 1'b0; else io_n_o <= 1'b0;
    do @(posedge clk_i); while (sel_n_i !== 1'b0);
    bi = dbi_n_i;
    cc = cc_n_i;
    if (st) begin
      stb_n_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      stb_n_o <= 1'b1;
    end
    repeat (hold_cyc) @(posedge clk_i);
    @(posedge clk_i);
    io_n_o  <= 1'b1;
    svc_n_o <= 1'b1;
    do @(posedge clk_i); while (sel_n_i !== 1'b1);
    {func_n_o, mod_n_o, addr_n_o} <= '1;
    dbo_n_o <= '1;
  endtask : seq
endmodule : pct_adapter
`default_nettype wire

// *** tb/test_pct_term.sv ***
// self-checking bench for the device termination block
`timescale 1ns/100ps
`default_nettype none
module test_pct_term;
  logic CLOCK_I = 0, SRST_I = 1, PSEL_I = 0, PENABLE_I = 0, PWRITE_I = 0;
  logic [7:0] PADDR_I = '0;
  logic [31:0] PWDATA_I = '0, PRDATA_O, q;
  logic PREADY_O, PSLVERR_O, IO_ACTIVE_N_I, ISVC_ACTIVE_N_I, STROBE_N_I, SEL_RESP_N_O, e;
  logic MACHINE_CHECK_HALT_N_I = 1, SYS_RESET_N_I = 1, POWER_ON_RESET_N_I = 1;
  logic DIAG_MODE_N_I = 1, DIAG_MOD_N_I = 1;
  logic [2:0] FUNC_N_I, CC_N_O, cc;
  logic [3:0] MOD_N_I, DEV_ADDR_N_I;
  logic [17:0] DBO_N_I, DBI_N_O, bi;
  logic [15:0] IRQ_N_O;
  int n_mismatch = 0, total_checks = 0, cyc = 0;
  //////////////////////////////////////////////////////////////////////////////////////////////
  pct_term #(.TMO_CYC(50)) dut_u (.CLOCK_I, .SRST_I, .PSEL_I, .PENABLE_I, .PWRITE_I,
    .PADDR_I, .PWDATA_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .IO_ACTIVE_N_I, .ISVC_ACTIVE_N_I,
    .STROBE_N_I, .FUNC_N_I, .MOD_N_I, .DEV_ADDR_N_I, .DBO_N_I, .MACHINE_CHECK_HALT_N_I,
    .SYS_RESET_N_I, .POWER_ON_RESET_N_I, .DIAG_MODE_N_I, .DIAG_MOD_N_I, .DBI_N_O, .IRQ_N_O,
    .CC_N_O, .SEL_RESP_N_O);
  pct_adapter a (.clk_i(CLOCK_I), .sel_n_i(SEL_RESP_N_O), .dbi_n_i(DBI_N_O), .cc_n_i(CC_N_O),
    .io_n_o(IO_ACTIVE_N_I), .svc_n_o(ISVC_ACTIVE_N_I), .stb_n_o(STROBE_N_I),
    .func_n_o(FUNC_N_I), .mod_n_o(MOD_N_I), .addr_n_o(DEV_ADDR_N_I), .dbo_n_o(DBO_N_I));
  initial begin
    forever #50 CLOCK_I = ~CLOCK_I;
  end
  //////////////////////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  always @(posedge CLOCK_I) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] s);
    total_checks++;
    if (x !== s) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, x, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge CLOCK_I);
    {PSEL_I, PENABLE_I, PWRITE_I, PADDR_I, PWDATA_I} <= {1'b1, 1'b0, w, ad, d};
    @(posedge CLOCK_I);
    PENABLE_I <= 1'b1;
    do @(posedge CLOCK_I); while (PREADY_O !== 1'b1);
    q = PRDATA_O;
    e = PSLVERR_O;
    {PSEL_I, PENABLE_I} <= 2'b00;
  endtask : apb
  task automatic rd(input logic [7:0] ad, input logic [31:0] x, input string nm);
    apb(1'b0, ad, '0);
    chk(nm, x, q);
  endtask : rd
  task automatic pins(input string nm, input logic [15:0] x);
    repeat (4) @(posedge CLOCK_I);
    chk(nm, {16'h0, x}, {16'h0, IRQ_N_O});
  endtask : pins
  //////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge CLOCK_I);
    SRST_I <= 1'b0;
    rd(pct_pkg::OFS_CTRL, 32'h0, "ctrl reset");
    rd(pct_pkg::OFS_CC, {26'h0, pct_pkg::CC_RST}, "cc reset");
    rd(8'h40, 32'h0, "unmapped");
    chk("slverr", 32'h1, {31'h0, e});
    $display("test registers done");
    apb(1, pct_pkg::OFS_CTRL, 32'h1);
    apb(1, pct_pkg::OFS_SEL, 32'h3);
    apb(1, pct_pkg::OFS_RDATA, 32'h1234);
    apb(1, pct_pkg::OFS_DEVID, 32'hBEEF);
    for (int i = 0; i < 2; i++) begin
      a.seq(0, {2'b00, i[0]}, 4'h5, 4'h3, 16'h0, 1, bi, cc);
      chk("read data", 32'h1234, {16'h0, ~bi[15:0]});
      chk("cc normal", {29'h0, pct_pkg::CC_RST[2:0]}, {29'h0, ~cc});
      a.seq(0, {2'b10, i[0]}, 4'h1, 4'h3, 16'h5A00 + 16'(i), 1, bi, cc);
      rd(pct_pkg::OFS_WDATA, 32'h5A00 + i, "write data");
      a.seq(0, i[0] ? pct_pkg::FN_RES1 : pct_pkg::FN_RES0, 4'h2, 4'h3, 16'h0, 1, bi, cc);
      chk("cc reject", {29'h0, pct_pkg::CC_RST[5:3]}, {29'h0, ~cc});
      chk("reject data", 32'h0, {16'h0, ~bi[15:0]});
    end
    a.seq(0, pct_pkg::FN_RDSTAT, pct_pkg::MOD_READID, 4'h3, 16'h0, 1, bi, cc);
    chk("read id", 32'hBEEF, {16'h0, ~bi[15:0]});
    a.seq(0, pct_pkg::FN_WRCTL, 4'h3, 4'h3, 16'h0F0F, 1, bi, cc);
    rd(pct_pkg::OFS_WCTL, 32'h0F0F, "write control");
    rd(pct_pkg::OFS_STATUS, 32'h3600, "status");
    chk("last dev func", 32'h36, {24'h0, q[15:12], 1'b0, q[10:8]});
    $display("test commands done");
    apb(1, pct_pkg::OFS_CTRL, 32'h5);
    a.seq(0, 3'b000, 4'h0, 4'h3, 16'h0, 0, bi, cc);
    rd(pct_pkg::OFS_RDATA, 32'h1234, "no strobe kept");
    a.seq(0, 3'b000, 4'h0, 4'h3, 16'h0, 1, bi, cc);
    rd(pct_pkg::OFS_RDATA, 32'h0, "read reset");
    $display("test read reset done");
    apb(1, pct_pkg::OFS_IRQ, 32'h8);
    pins("irq set", 16'hFFF7);
    apb(1, pct_pkg::OFS_IIB, 32'hC3);
    a.seq(1, 3'b000, 4'h0, 4'h3, 16'h0, 1, bi, cc);
    chk("service byte", 32'hC3, {16'h0, ~bi[15:0]});
    pins("irq serviced", 16'hFFFF);
    rd(pct_pkg::OFS_IIB, 32'h0, "iib cleared");
    apb(1, pct_pkg::OFS_IRQ, 32'h8);
    a.seq(0, pct_pkg::FN_WRCTL, pct_pkg::MOD_DEVRST, 4'h3, 16'h0, 1, bi, cc);
    pins("device reset", 16'hFFFF);
    apb(1, pct_pkg::OFS_IRQ, 32'h8);
    MACHINE_CHECK_HALT_N_I <= 1'b0;
    pins("halt", 16'hFFFF);
    MACHINE_CHECK_HALT_N_I <= 1'b1;
    rd(pct_pkg::OFS_STATUS, 32'h3620, "status");
    chk("halt seen", 32'h1, {31'h0, q[5]});
    $display("test interrupt done");
    for (int i = 0; i < 2; i++) begin
      apb(1, pct_pkg::OFS_IRQ, 32'h8);
      {SYS_RESET_N_I, POWER_ON_RESET_N_I} <= i[0] ? 2'b10 : 2'b01;
      pins("link reset", 16'hFFFF);
      {SYS_RESET_N_I, POWER_ON_RESET_N_I} <= 2'b11;
      repeat (3) @(posedge CLOCK_I);
      rd(pct_pkg::OFS_CTRL, 32'h0, "ctrl cleared");
      apb(1, pct_pkg::OFS_CTRL, 32'h1);
    end
    apb(1, pct_pkg::OFS_CTRL, 32'h3);
    a.seq(0, 3'b000, 4'h0, 4'h3, 16'h0, 1, bi, cc);
    chk("dbi parity", 32'h3, {30'h0, ~bi[17:16]});
    a.hold_cyc = 60;
    a.seq(0, 3'b000, 4'h0, 4'h3, 16'h0, 0, bi, cc);
    a.hold_cyc = 0;
    {DIAG_MODE_N_I, DIAG_MOD_N_I} <= 2'b00;
    repeat (4) @(posedge CLOCK_I);
    rd(pct_pkg::OFS_STATUS, 32'h301A, "status");
    chk("timeout", 32'h1, {31'h0, q[1]});
    chk("diag lines", 32'h3, {30'h0, q[4:3]});
    $display("test resets done");
    conclude();
  end
endmodule : test_pct_term
`default_nettype wire
